// [shared/dlc_pkg.sv]
/*
 Constants and carrier types for the dynamics, equaliser and loopback
 configuration block. Assumes a 32-bit AHB-Lite bus with word registers
 at byte address = 4 * register index.
*/
`default_nettype none
package dlc_pkg;
   // Register indices, byte address is four times the index
   localparam logic [9:0] IDX_GATE_CTRL   = 10'h114;
   localparam logic [9:0] IDX_GATE_SLOPES = 10'h116;
   localparam logic [9:0] IDX_COMP_KNEE   = 10'h117;
   localparam logic [9:0] IDX_GATE_KNEE   = 10'h118;
   localparam logic [9:0] IDX_LOOPBACK    = 10'h11D;
   localparam logic [9:0] IDX_STATUS      = 10'h11E;
   localparam logic [9:0] IDX_EQ_CTRL     = 10'h14F;
   localparam logic [9:0] IDX_EQ_GAIN_LO  = 10'h150;
   localparam logic [9:0] IDX_EQ_GAIN_HI  = 10'h151;

   // Storage slots of the writable registers
   localparam int NREG = 8;
   localparam logic [2:0] S_GATE_CTRL   = 3'd0;
   localparam logic [2:0] S_GATE_SLOPES = 3'd1;
   localparam logic [2:0] S_COMP_KNEE   = 3'd2;
   localparam logic [2:0] S_GATE_KNEE   = 3'd3;
   localparam logic [2:0] S_LOOPBACK    = 3'd4;
   localparam logic [2:0] S_EQ_CTRL     = 3'd5;
   localparam logic [2:0] S_EQ_GAIN_LO  = 3'd6;
   localparam logic [2:0] S_EQ_GAIN_HI  = 3'd7;

   // Writable bits per slot; reserved bits store nothing, read zero
   localparam logic [15:0] REG_MASK [NREG] = '{
      16'h0090, 16'hFFFF, 16'h07FF, 16'h03FF,
      16'h0003, 16'h0007, 16'hFFFE, 16'hFFC0};
   // Values after reset per slot
   localparam logic [15:0] REG_RESET [NREG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0004, 16'h6318, 16'h6300};

   // Field positions
   localparam int GATE_ENA_BIT    = 7;
   localparam int KNEE2_OP_BIT    = 4;
   localparam int MINGAIN_LSB     = 12;
   localparam int QR_THR_LSB      = 10;
   localparam int QR_DCY_LSB      = 8;
   localparam int NG_EXP_LSB      = 6;
   localparam int HI_COMP_LSB     = 3;
   localparam int LO_COMP_LSB     = 0;
   localparam int KNEE_IP_LSB     = 5;
   localparam int KNEE_OP_LSB     = 0;
   localparam int KNEE2_IP_LSB    = 5;
   localparam int KNEE2_OP_LSB    = 0;
   localparam int LPB_ENA_BIT     = 1;
   localparam int LPB_MODE_BIT    = 0;
   localparam int EQ_SHARE_BIT    = 2;
   localparam int EQ_SEL_BIT      = 1;
   localparam int EQ_RUN_BIT      = 0;
   localparam int BAND1_LSB       = 11;
   localparam int BAND2_LSB       = 6;
   localparam int BAND3_LSB       = 1;
   localparam int BAND4_LSB       = 11;
   localparam int BAND5_LSB       = 6;

   // Dynamics controller settings as seen by the datapath
   typedef struct packed {
      logic       noise_gate_enable;
      logic [3:0] gate_min_gain;
      logic [1:0] quick_release_threshold;
      logic [1:0] quick_release_decay;
      logic [1:0] gate_expansion_slope;
      logic [2:0] upper_compression_slope;
      logic [2:0] lower_compression_slope;
      logic [5:0] knee_input_level;
      logic [4:0] knee_output_level;
      logic       gate_knee_input_apply;
      logic [4:0] gate_knee_input_level;
      logic       gate_knee_output_apply;
      logic [4:0] gate_knee_output_level;
   } dlc_dyn_cfg_s;

   // Equaliser settings as seen by the datapath
   typedef struct packed {
      logic       equaliser_enable;
      logic       left_uses_right_coeff;
      logic       right_uses_left_coeff;
      logic [4:0] left_band1_gain;
      logic [4:0] left_band2_gain;
      logic [4:0] left_band3_gain;
      logic [4:0] left_band4_gain;
      logic [4:0] left_band5_gain;
   } dlc_eq_cfg_s;
endpackage
`default_nettype wire

// [design/dlc_regs.sv]
/*
 Configuration register bank for the dynamics controller, the audio
 interface loopback mux and the 5-band equaliser left gains, with an
 AHB-Lite slave. Assumes one clock, samples from logic on that clock,
 and a single bus master issuing word transfers.
*/
// The AHB-Lite slave port was chosen for this implementation.
// What this block does
// - 4-bit gate minimum gain, -36dB to 30dB
// - 2-bit quick-release crest threshold, 12dB-30dB
// - 2-bit quick-release decay time per 6dB
// - 2-bit gate expansion slope 1,2,4,8
// - 3-bit upper compressor slope, 101 limiter
// - 3-bit lower compressor slope, 1 down to 0
// - 6-bit compressor knee input, 0.75dB steps
// - 5-bit compressor knee output, 0.75dB steps
// - 5-bit gate knee input, 1.5dB steps
// - Gate knee input applies only when gate enabled
// - 5-bit gate knee output, 1.5dB steps
// - Gate knee output applies only when enabled
// - Loopback routes ADC and DAC mean to outputs
// - Equaliser enable; sharing bit resets to one
// - Select bit picks shared left or right set
// - Left band gains 5-bit, default 0dB code
// - Left bands packed in two gain registers
// - Noise gate enable gates only the gate knee input
`timescale 1ns/1ps
`default_nettype none
module dlc_regs #(
   parameter int SW = 24                  // Audio sample width
) (
   input  wire logic                 sys_clk,     // 100 MHz clock
   input  wire logic                 reset_n,     // Async reset, low
   input  wire logic                 hsel,        // Slave select
   input  wire logic [31:0]          haddr,       // Byte address
   input  wire logic [1:0]           htrans,      // Transfer type
   input  wire logic                 hwrite,      // Write when high
   input  wire logic [2:0]           hsize,       // Word only
   input  wire logic [31:0]          hwdata,      // Write data
   input  wire logic                 hready,      // Bus ready
   output logic [31:0]               hrdata,      // Read data
   output logic                      hreadyout,   // Always ready
   output logic                      hresp,       // Always OKAY
   input  wire logic                 smp_valid,   // Sample strobe
   input  wire logic signed [SW-1:0] adc_left,    // Left ADC sample
   input  wire logic signed [SW-1:0] adc_right,   // Right ADC sample
   input  wire logic signed [SW-1:0] dac_left,    // Left DAC sample
   input  wire logic signed [SW-1:0] dac_right,   // Right DAC sample
   output logic signed [SW-1:0]      aud_left,    // Interface left
   output logic signed [SW-1:0]      aud_right,   // Interface right
   output logic                      aud_valid,   // Output strobe
   output dlc_pkg::dlc_dyn_cfg_s     dyn_cfg,     // Dynamics settings
   output dlc_pkg::dlc_eq_cfg_s      eq_cfg       // Equaliser settings
);

   // Register storage, one word per slot
   logic [15:0] regs_q [dlc_pkg::NREG];

   // Bus pipeline state
   logic        wr_pend_q;
   logic [2:0]  wr_slot_q;
   logic [31:0] hrdata_q;
   logic        hreadyout_q;
   logic        hresp_q;

   // Datapath output flops
   logic signed [SW-1:0] aud_left_q;
   logic signed [SW-1:0] aud_right_q;
   logic                 aud_valid_q;
   dlc_pkg::dlc_dyn_cfg_s dyn_cfg_q;
   dlc_pkg::dlc_eq_cfg_s  eq_cfg_q;

   // Address phase decode
   logic        take;
   logic        addr_ok;
   logic [9:0]  idx;
   logic        slot_hit;
   logic [2:0]  slot;
   logic [15:0] rd_word;
   logic [15:0] status_word;

   assign take    = hsel & hready & htrans[1];
   assign idx     = haddr[11:2];
   assign addr_ok = (haddr[31:12] == 20'h0_0000) & (haddr[1:0] == 2'b00);

   // Index to storage slot; unmapped indices miss
   always_comb begin
      slot_hit = addr_ok;
      slot     = dlc_pkg::S_GATE_CTRL;
      case (idx)
         dlc_pkg::IDX_GATE_CTRL:   slot = dlc_pkg::S_GATE_CTRL;
         dlc_pkg::IDX_GATE_SLOPES: slot = dlc_pkg::S_GATE_SLOPES;
         dlc_pkg::IDX_COMP_KNEE:   slot = dlc_pkg::S_COMP_KNEE;
         dlc_pkg::IDX_GATE_KNEE:   slot = dlc_pkg::S_GATE_KNEE;
         dlc_pkg::IDX_LOOPBACK:    slot = dlc_pkg::S_LOOPBACK;
         dlc_pkg::IDX_EQ_CTRL:     slot = dlc_pkg::S_EQ_CTRL;
         dlc_pkg::IDX_EQ_GAIN_LO:  slot = dlc_pkg::S_EQ_GAIN_LO;
         dlc_pkg::IDX_EQ_GAIN_HI:  slot = dlc_pkg::S_EQ_GAIN_HI;
         default:                  slot_hit = 1'b0;
      endcase
   end

   // Status shows what the datapath is really doing
   assign status_word = {13'h0000,
                         dyn_cfg_q.noise_gate_enable,
                         eq_cfg_q.equaliser_enable,
                         regs_q[dlc_pkg::S_LOOPBACK][dlc_pkg::LPB_ENA_BIT]};

   // Read word, forwarding a write still in its data phase
   always_comb begin
      rd_word = 16'h0000;
      if (slot_hit) begin
         if (wr_pend_q && (wr_slot_q == slot)) begin
            rd_word = hwdata[15:0] & dlc_pkg::REG_MASK[slot];
         end else begin
            rd_word = regs_q[slot];
         end
      end else if (addr_ok && (idx == dlc_pkg::IDX_STATUS)) begin
         rd_word = status_word;
      end
   end

   // Address phase capture; write lands at the end of its data phase
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_q <= 1'b0;
         wr_slot_q <= 3'd0;
      end else begin
         wr_pend_q <= take & hwrite & slot_hit;
         wr_slot_q <= slot;
      end
   end

   // Read data is registered so it stands through the data phase
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_q <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata_q <= {16'h0000, rd_word};
      end else begin
         hrdata_q <= 32'h0000_0000;
      end
   end

   // Zero wait states, never an error; unmapped reads zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end
   end

   // Register storage; reserved codes stored, reserved bits dropped
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < dlc_pkg::NREG; i++) begin
            regs_q[i] <= dlc_pkg::REG_RESET[i];
         end
      end else if (wr_pend_q) begin
         regs_q[wr_slot_q] <= hwdata[15:0]
                              & dlc_pkg::REG_MASK[wr_slot_q];
      end
   end

   // Field views of the stored words
   logic [15:0] r_ctl;
   logic [15:0] r_slp;
   logic [15:0] r_knee;
   logic [15:0] r_gknee;
   logic [15:0] r_tlb;
   logic [15:0] r_eq;
   logic [15:0] r_glo;
   logic [15:0] r_ghi;
   logic        gate_on;

   assign r_ctl   = regs_q[dlc_pkg::S_GATE_CTRL];
   assign r_slp   = regs_q[dlc_pkg::S_GATE_SLOPES];
   assign r_knee  = regs_q[dlc_pkg::S_COMP_KNEE];
   assign r_gknee = regs_q[dlc_pkg::S_GATE_KNEE];
   assign r_tlb   = regs_q[dlc_pkg::S_LOOPBACK];
   assign r_eq    = regs_q[dlc_pkg::S_EQ_CTRL];
   assign r_glo   = regs_q[dlc_pkg::S_EQ_GAIN_LO];
   assign r_ghi   = regs_q[dlc_pkg::S_EQ_GAIN_HI];
   assign gate_on = r_ctl[dlc_pkg::GATE_ENA_BIT];

   // Dynamics settings, one cycle behind the registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dyn_cfg_q <= '0;
      end else begin
         dyn_cfg_q.noise_gate_enable <= gate_on;
         dyn_cfg_q.gate_min_gain <=
            r_slp[dlc_pkg::MINGAIN_LSB +: 4];
         dyn_cfg_q.quick_release_threshold <=
            r_slp[dlc_pkg::QR_THR_LSB +: 2];
         dyn_cfg_q.quick_release_decay <=
            r_slp[dlc_pkg::QR_DCY_LSB +: 2];
         dyn_cfg_q.gate_expansion_slope <=
            r_slp[dlc_pkg::NG_EXP_LSB +: 2];
         dyn_cfg_q.upper_compression_slope <=
            r_slp[dlc_pkg::HI_COMP_LSB +: 3];
         dyn_cfg_q.lower_compression_slope <=
            r_slp[dlc_pkg::LO_COMP_LSB +: 3];
         dyn_cfg_q.knee_input_level <=
            r_knee[dlc_pkg::KNEE_IP_LSB +: 6];
         dyn_cfg_q.knee_output_level <=
            r_knee[dlc_pkg::KNEE_OP_LSB +: 5];
         dyn_cfg_q.gate_knee_input_level <=
            r_gknee[dlc_pkg::KNEE2_IP_LSB +: 5];
         dyn_cfg_q.gate_knee_output_level <=
            r_gknee[dlc_pkg::KNEE2_OP_LSB +: 5];
         // Knee2 input is meaningless without the gate
         dyn_cfg_q.gate_knee_input_apply <= gate_on;
         dyn_cfg_q.gate_knee_output_apply <=
            r_ctl[dlc_pkg::KNEE2_OP_BIT];
      end
   end

   // Equaliser settings and coefficient set routing
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         eq_cfg_q <= '0;
      end else begin
         eq_cfg_q.equaliser_enable <=
            r_eq[dlc_pkg::EQ_RUN_BIT];
         // Sharing off: each channel keeps its own set
         eq_cfg_q.left_uses_right_coeff <=
            r_eq[dlc_pkg::EQ_SHARE_BIT]
            & r_eq[dlc_pkg::EQ_SEL_BIT];
         eq_cfg_q.right_uses_left_coeff <=
            r_eq[dlc_pkg::EQ_SHARE_BIT]
            & ~r_eq[dlc_pkg::EQ_SEL_BIT];
         eq_cfg_q.left_band1_gain <=
            r_glo[dlc_pkg::BAND1_LSB +: 5];
         eq_cfg_q.left_band2_gain <=
            r_glo[dlc_pkg::BAND2_LSB +: 5];
         eq_cfg_q.left_band3_gain <=
            r_glo[dlc_pkg::BAND3_LSB +: 5];
         eq_cfg_q.left_band4_gain <=
            r_ghi[dlc_pkg::BAND4_LSB +: 5];
         eq_cfg_q.left_band5_gain <=
            r_ghi[dlc_pkg::BAND5_LSB +: 5];
      end
   end

   // DAC mean; one extra bit so the sum cannot overflow
   logic signed [SW:0]   dac_sum;
   logic signed [SW-1:0] dac_mean;

   assign dac_sum  = {dac_left[SW-1], dac_left}
                   + {dac_right[SW-1], dac_right};
   assign dac_mean = dac_sum[SW:1];

   // Loopback mux; disabled means the normal ADC record path
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aud_left_q  <= '0;
         aud_right_q <= '0;
      end else if (smp_valid) begin
         if (!r_tlb[dlc_pkg::LPB_ENA_BIT]) begin
            aud_left_q  <= adc_left;
            aud_right_q <= adc_right;
         end else if (!r_tlb[dlc_pkg::LPB_MODE_BIT]) begin
            aud_left_q  <= adc_left;
            aud_right_q <= dac_mean;
         end else begin
            aud_left_q  <= dac_mean;
            aud_right_q <= adc_right;
         end
      end
   end

   // Output strobe follows each taken sample by one cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aud_valid_q <= 1'b0;
      end else begin
         aud_valid_q <= smp_valid;
      end
   end

   // Every output straight from a flop
   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;
   assign aud_left  = aud_left_q;
   assign aud_right = aud_right_q;
   assign aud_valid = aud_valid_q;
   assign dyn_cfg   = dyn_cfg_q;
   assign eq_cfg    = eq_cfg_q;

endmodule
`default_nettype wire

// [dv/dlc_checker.sv]
/*
 Concurrent checks on the ports of the configuration register bank.
 Assumes hready is looped from hreadyout and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dlc_checker #(
   parameter int SW = 24                // Sample width
) (
   input wire logic                 sys_clk,   // Clock
   input wire logic                 reset_n,   // Async reset, low
   input wire logic                 hsel,      // Select
   input wire logic [31:0]          haddr,     // Byte address
   input wire logic [1:0]           htrans,    // Transfer type
   input wire logic                 hwrite,    // Write flag
   input wire logic [31:0]          hwdata,    // Write data
   input wire logic                 hready,    // Bus ready
   input wire logic [31:0]          hrdata,    // Read data
   input wire logic                 hreadyout, // Slave ready
   input wire logic                 hresp,     // Response
   input wire logic                 smp_valid, // Sample strobe
   input wire logic signed [SW-1:0] adc_left,  // Left ADC
   input wire logic signed [SW-1:0] adc_right, // Right ADC
   input wire logic signed [SW-1:0] dac_left,  // Left DAC
   input wire logic signed [SW-1:0] dac_right, // Right DAC
   input wire logic signed [SW-1:0] aud_left,  // Output left
   input wire logic signed [SW-1:0] aud_right, // Output right
   input wire logic                 aud_valid, // Output strobe
   input wire dlc_pkg::dlc_dyn_cfg_s dyn_cfg,  // Dynamics settings
   input wire dlc_pkg::dlc_eq_cfg_s  eq_cfg    // Equaliser settings
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   localparam logic [31:0] A_SLP =
      {20'h0_0000, dlc_pkg::IDX_GATE_SLOPES, 2'b00};
   localparam logic [31:0] A_GKN = {20'h0_0000, dlc_pkg::IDX_GATE_KNEE, 2'b00};
   localparam logic [31:0] A_GLO =
      {20'h0_0000, dlc_pkg::IDX_EQ_GAIN_LO, 2'b00};
   // Tracks the read data phase; outside it hrdata must be quiet
   logic rd_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 1'b0;
      end else begin
         rd_q <= hsel && hready && htrans[1] && !hwrite;
      end
   end
   // One bit wider so the DAC sum cannot wrap
   logic signed [SW:0] dac_sum;
   assign dac_sum = {dac_left[SW-1], dac_left} + {dac_right[SW-1], dac_right};
   // Write address phase then its data phase
   sequence s_wr(logic [31:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == a ##1 hready;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
      else $error("read data outside read data phase");
   a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_min_gain: assert property (s_wr(A_SLP) |-> ##2
      dyn_cfg.gate_min_gain == $past(hwdata[15:12], 2))
      else $error("minimum gain did not follow write");
   a_knee_write: assert property (s_wr(A_GKN) |-> ##2
      dyn_cfg.gate_knee_input_level == $past(hwdata[9:5], 2))
      else $error("gate knee did not follow write");
   a_band_write: assert property (s_wr(A_GLO) |-> ##2
      eq_cfg.left_band1_gain == $past(hwdata[15:11], 2))
      else $error("band one gain did not follow write");
   a_gate_apply: assert property (dyn_cfg.gate_knee_input_apply ==
      dyn_cfg.noise_gate_enable)
      else $error("gate knee applied without gate enable");
   a_reset_eq: assert property ($rose(reset_n) |=>
      eq_cfg.right_uses_left_coeff && eq_cfg.left_band1_gain == 5'h0C
      && eq_cfg.left_band5_gain == 5'h0C)
      else $error("equaliser defaults wrong after reset");
   a_valid_pulse: assert property (smp_valid |=> aud_valid)
      else $error("no output strobe after sample");
   a_valid_idle: assert property (!smp_valid |=> !aud_valid)
      else $error("output strobe without sample");
   a_route_left: assert property (smp_valid |=> aud_left == $past(adc_left)
      || aud_left == $past(dac_sum[SW:1]))
      else $error("left output neither ADC nor DAC mean");
   a_one_adc: assert property (smp_valid |=> aud_left == $past(adc_left)
      || aud_right == $past(adc_right))
      else $error("neither output carries its ADC");
endmodule
bind dlc_regs dlc_checker #(.SW(SW)) u_chk (.sys_clk, .reset_n, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .smp_valid, .adc_left, .adc_right, .dac_left, .dac_right, .aud_left,
   .aud_right, .aud_valid, .dyn_cfg, .eq_cfg);
`default_nettype wire

// [dv/tb_dynamics_eq_loopback_config.sv]
/*
 Self-checking bench for the configuration register bank.
 Assumes default sample width and hready looped from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module tb_dynamics_eq_loopback_config;
   logic                  sys_clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  hsel = 1'b0;
   logic [31:0]           haddr = 32'h0000_0000;
   logic [1:0]            htrans = 2'b00;
   logic                  hwrite = 1'b0;
   logic [31:0]           hwdata = 32'h0000_0000;
   logic                  smp_valid = 1'b0;
   logic signed [23:0]    adc_left = '0, adc_right = '0;
   logic signed [23:0]    dac_left = '0, dac_right = '0;
   logic [31:0]           hrdata;
   logic                  hreadyout, hresp, aud_valid;
   logic signed [23:0]    aud_left, aud_right;
   dlc_pkg::dlc_dyn_cfg_s dyn_cfg;
   dlc_pkg::dlc_eq_cfg_s  eq_cfg;
   int                    error_cnt = 0;
   int                    num_checks = 0;
   int                    cyc = 0;
   dlc_regs DUT (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .smp_valid, .adc_left, .adc_right, .dac_left, .dac_right,
      .aud_left, .aud_right, .aud_valid, .dyn_cfg, .eq_cfg);
   // Free-running 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   task automatic give_verdict;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the roughly 140 cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // One single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [9:0] ix,
                      input logic [31:0] wd, output logic [31:0] rv);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, ix, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic wr(input logic [9:0] ix, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, ix, d, x);
   endtask
   task automatic rc(input logic [9:0] ix, input logic [15:0] e);
      logic [31:0] x;
      bus(1'b0, ix, 32'h0000_0000, x);
      `CHK(x, {16'h0000, e})
   endtask
   // Write then read straight back, one idle address phase between
   task automatic wrc(input logic [9:0] ix, input logic [31:0] d,
                      input logic [15:0] e);
      wr(ix, d);
      rc(ix, e);
   endtask
   task automatic t_reset_vals;
      rc(dlc_pkg::IDX_GATE_CTRL, 16'h0000);
      rc(dlc_pkg::IDX_GATE_SLOPES, 16'h0000);
      rc(dlc_pkg::IDX_COMP_KNEE, 16'h0000);
      rc(dlc_pkg::IDX_GATE_KNEE, 16'h0000);
      rc(dlc_pkg::IDX_LOOPBACK, 16'h0000);
      rc(dlc_pkg::IDX_EQ_CTRL, 16'h0004);
      rc(dlc_pkg::IDX_EQ_GAIN_LO, 16'h6318);
      rc(dlc_pkg::IDX_EQ_GAIN_HI, 16'h6300);
   endtask
   // All ones: only real fields stick, upper half ignored
   task automatic t_masks;
      wrc(dlc_pkg::IDX_GATE_CTRL, 32'hFFFF_FFFF, 16'h0090);
      wrc(dlc_pkg::IDX_GATE_SLOPES, 32'hFFFF_FFFF, 16'hFFFF);
      wrc(dlc_pkg::IDX_COMP_KNEE, 32'hFFFF_FFFF, 16'h07FF);
      wrc(dlc_pkg::IDX_GATE_KNEE, 32'hFFFF_FFFF, 16'h03FF);
      wrc(dlc_pkg::IDX_LOOPBACK, 32'hFFFF_FFFF, 16'h0003);
      wrc(dlc_pkg::IDX_EQ_CTRL, 32'hFFFF_FFFF, 16'h0007);
      wrc(dlc_pkg::IDX_EQ_GAIN_LO, 32'hFFFF_FFFF, 16'hFFFE);
      wrc(dlc_pkg::IDX_EQ_GAIN_HI, 32'hFFFF_FFFF, 16'hFFC0);
      wrc(10'h120, 32'h0000_FFFF, 16'h0000);
      wrc(dlc_pkg::IDX_GATE_SLOPES, 32'h0000_C3F7, 16'hC3F7);
   endtask
   // Nonzero codes reach the datapath fields
   task automatic t_dyn;
      wr(dlc_pkg::IDX_GATE_CTRL, 32'h0000_0000);
      wr(dlc_pkg::IDX_GATE_SLOPES, 32'h0000_B6E1);
      wr(dlc_pkg::IDX_COMP_KNEE, 32'h0000_079E);
      wr(dlc_pkg::IDX_GATE_KNEE, 32'h0000_03FF);
      repeat (2) @(posedge sys_clk);
      `CHK(dyn_cfg.gate_min_gain, 4'hB)
      `CHK(dyn_cfg.quick_release_threshold, 2'h1)
      `CHK(dyn_cfg.quick_release_decay, 2'h2)
      `CHK(dyn_cfg.gate_expansion_slope, 2'h3)
      `CHK(dyn_cfg.upper_compression_slope, 3'h4)
      `CHK(dyn_cfg.lower_compression_slope, 3'h1)
      `CHK(dyn_cfg.knee_input_level, 6'h3C)
      `CHK(dyn_cfg.knee_output_level, 5'h1E)
      `CHK(dyn_cfg.gate_knee_input_level, 5'h1F)
      `CHK(dyn_cfg.gate_knee_output_level, 5'h1F)
      for (int i = 0; i < 2; i++) begin
         wr(dlc_pkg::IDX_GATE_CTRL, (i == 0) ? 32'h0000_0080 : 32'h0000_0010);
         repeat (2) @(posedge sys_clk);
         `CHK(dyn_cfg.noise_gate_enable, 1'(i == 0))
         `CHK(dyn_cfg.gate_knee_input_apply, 1'(i == 0))
         `CHK(dyn_cfg.gate_knee_output_apply, 1'(i == 1))
      end
   endtask
   // Every sharing, select and enable combination, then band packing
   task automatic t_eq;
      logic [2:0] b;
      for (int v = 0; v < 8; v++) begin
         b = 3'(v);
         wr(dlc_pkg::IDX_EQ_CTRL, 32'(b));
         repeat (2) @(posedge sys_clk);
         `CHK(eq_cfg.equaliser_enable, b[0])
         `CHK(eq_cfg.left_uses_right_coeff, b[2] & b[1])
         `CHK(eq_cfg.right_uses_left_coeff, b[2] & ~b[1])
      end
      wr(dlc_pkg::IDX_EQ_GAIN_LO, 32'h0000_C018);
      wrc(dlc_pkg::IDX_EQ_GAIN_HI, 32'h0000_C840, 16'hC840);
      `CHK(eq_cfg.left_band1_gain, 5'h18)
      `CHK(eq_cfg.left_band2_gain, 5'h00)
      `CHK(eq_cfg.left_band3_gain, 5'h0C)
      `CHK(eq_cfg.left_band4_gain, 5'h19)
      `CHK(eq_cfg.left_band5_gain, 5'h01)
   endtask
   // Odd negative DAC sum: a truncating mean would give FF_FFFF
   task automatic smp(input logic [1:0] lb, input logic [23:0] el, er);
      wr(dlc_pkg::IDX_LOOPBACK, 32'(lb));
      adc_left <= 24'h12_3456;
      adc_right <= 24'h65_4321;
      dac_left <= 24'hFF_FFFB;
      dac_right <= 24'h00_0002;
      smp_valid <= 1'b1;
      @(posedge sys_clk);
      smp_valid <= 1'b0;
      @(posedge sys_clk);
      `CHK(aud_valid, 1'b1)
      `CHK(aud_left, el)
      `CHK(aud_right, er)
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_reset_vals();
      t_masks();
      t_dyn();
      t_eq();
      smp(2'b00, 24'h12_3456, 24'h65_4321);
      smp(2'b01, 24'h12_3456, 24'h65_4321);
      smp(2'b10, 24'h12_3456, 24'hFF_FFFE);
      smp(2'b11, 24'hFF_FFFE, 24'h65_4321);
      // Status is read only: gate off, equaliser on, loopback on
      wrc(dlc_pkg::IDX_STATUS, 32'h0000_FFFF, 16'h0003);
      give_verdict();
   end
endmodule
`default_nettype wire
